// >>> verilog/fws_defs.vh
/*
 * constants for the flash status-polling controller: register offsets,
 * field positions, command codes and bus timing counts.
 * assumes a 10 MHz pclk and an asynchronous parallel flash bus.
 */
`ifndef FWS_DEFS_VH
`define FWS_DEFS_VH

// register offsets (byte addresses)
`define FWS_OFF_CTRL 12'h000
`define FWS_OFF_ADDR 12'h004
`define FWS_OFF_DATA 12'h008
`define FWS_OFF_STAT 12'h00C
`define FWS_OFF_RDAT 12'h010
`define FWS_OFF_PCNT 12'h014

// ctrl fields
`define FWS_CTRL_GO 0
`define FWS_CTRL_OP_LO 1
`define FWS_CTRL_OP_HI 3

// operation codes
`define FWS_OP_READ 3'h0
`define FWS_OP_WRITE 3'h1
`define FWS_OP_PROGRAM 3'h2
`define FWS_OP_SECT_ERASE 3'h3
`define FWS_OP_CHIP_ERASE 3'h4
`define FWS_OP_SUSPEND 3'h5
`define FWS_OP_RESUME 3'h6
`define FWS_OP_RESET 3'h7

// status fields
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_FAIL 2
`define FWS_ST_RYBY 3
`define FWS_ST_SUSP 4

// status bit positions in the flash data byte
`define FWS_DPOLL 7
`define FWS_TOG1 6
`define FWS_TFAIL 5
`define FWS_ETIMER 3
`define FWS_TOG2 2

// command bytes
`define FWS_CMD_AA 8'hAA
`define FWS_CMD_55 8'h55
`define FWS_CMD_PROG 8'hA0
`define FWS_CMD_ERASE 8'h80
`define FWS_CMD_CHIP 8'h10
`define FWS_CMD_SECT 8'h30
`define FWS_CMD_SUSP 8'hB0
`define FWS_CMD_RESUME 8'h30
`define FWS_CMD_RESET 8'hF0
`define FWS_UNLOCK_A1 20'h0_0AAA
`define FWS_UNLOCK_A2 20'h0_0555

// bus timing, nanoseconds and cycles (100 ns period)
`define FWS_CLK_NS 100
`define FWS_STROBE_NS 200
`define FWS_STROBE_CYC ((`FWS_STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RESET_VAL 32'h0000_0000

`endif

// >>> verilog/fws_strobe.v
/*
 * single flash bus cycle engine: drives one read or write strobe for a
 * fixed number of clocks. assumes caller holds addr/data while busy.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fws_defs.vh"

module fws_strobe #(
    parameter integer CYC = `FWS_STROBE_CYC
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // request
    input wire start,
    input wire is_write,
    // flash strobes
    output reg ce_n,
    output reg oe_n,
    output reg we_n,
    output reg data_oe,
    // completion pulse, read data valid then
    output reg done
);
    reg [7:0] cnt_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            data_oe <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && ce_n) begin
                cnt_reg <= CYC[7:0];
                ce_n <= 1'b0;
                oe_n <= is_write;
                we_n <= ~is_write;
                data_oe <= is_write;
            end else if (!ce_n) begin
                if (cnt_reg == 8'h01) begin
                    // strobes rise together; write data latches here
                    ce_n <= 1'b1;
                    oe_n <= 1'b1;
                    we_n <= 1'b1;
                    data_oe <= 1'b0;
                    done <= 1'b1;
                end
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/fws_ctrl.v
/*
 * apb-controlled host for a parallel nor flash: issues program, erase,
 * suspend, resume and reset sequences, and polls write status after program and erase.
 * assumes flash is in byte mode and inputs are synchronous to pclk.
 */
// The register addresses and register access over APB are this design's own decisions.
// Contract
// - host reads status at program address
// - host reads erase status inside erasing sector
// - after true data, take data from next read
// - host combines both toggle bits for mode; the code compares only toggle_bit_one
// - timeout_fail_bit set; host issues reset
// - host reads status twice to compare toggles
`timescale 1ns/1ns
`default_nettype none
`include "fws_defs.vh"

module fws_ctrl #(
    parameter integer AW = 20
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // flash bus
    output reg [AW-1:0] flash_addr,
    output reg [7:0] flash_dq_out,
    input wire [7:0] flash_dq_in,
    output reg flash_dq_oe,
    output reg flash_ce_n,
    output reg flash_oe_n,
    output reg flash_we_n,
    input wire ready_busy_n,
    // activity
    output reg busy
);
    localparam [3:0] S_IDLE = 4'd0;
    localparam [3:0] S_CMD = 4'd1;
    localparam [3:0] S_CMDW = 4'd2;
    localparam [3:0] S_POLL1 = 4'd3;
    localparam [3:0] S_POLL1W = 4'd4;
    localparam [3:0] S_POLL2 = 4'd5;
    localparam [3:0] S_POLL2W = 4'd6;
    localparam [3:0] S_FINAL = 4'd7;
    localparam [3:0] S_FINALW = 4'd8;

    reg [3:0] state_reg;
    reg [2:0] op_reg;
    reg [2:0] step_reg;
    reg [2:0] nsteps_reg;
    reg [AW-1:0] addr_reg;
    reg [7:0] data_reg;
    reg [7:0] rdat_reg;
    reg [7:0] first_reg;
    reg done_reg;
    reg fail_reg;
    reg susp_reg;
    reg ryby_reg;
    reg [15:0] pcnt_reg;
    reg go_reg;
    reg recheck_reg;
    reg is_wr_reg;
    reg [AW-1:0] cyc_addr;
    reg [7:0] cyc_data;
    wire ce_w;
    wire oe_w;
    wire we_w;
    wire doe_w;
    wire cyc_done;

    fws_strobe u_strobe (
        .pclk(pclk),
        .presetn(presetn),
        .start(go_reg),
        .is_write(is_wr_reg),
        .ce_n(ce_w),
        .oe_n(oe_w),
        .we_n(we_w),
        .data_oe(doe_w),
        .done(cyc_done)
    );

    // command sequence table: one bus write per step
    always @* begin
        cyc_addr = `FWS_UNLOCK_A1;
        cyc_data = `FWS_CMD_AA;
        case (op_reg)
            `FWS_OP_PROGRAM: begin
                case (step_reg)
                    3'd1: begin cyc_addr = `FWS_UNLOCK_A2; cyc_data = `FWS_CMD_55; end
                    3'd2: cyc_data = `FWS_CMD_PROG;
                    3'd3: begin cyc_addr = addr_reg; cyc_data = data_reg; end
                    default: cyc_data = `FWS_CMD_AA;
                endcase
            end
            `FWS_OP_SECT_ERASE, `FWS_OP_CHIP_ERASE: begin
                case (step_reg)
                    3'd1, 3'd4: begin cyc_addr = `FWS_UNLOCK_A2; cyc_data = `FWS_CMD_55; end
                    3'd2: cyc_data = `FWS_CMD_ERASE;
                    3'd5: begin
                        if (op_reg == `FWS_OP_SECT_ERASE) begin
                            cyc_addr = addr_reg;
                            cyc_data = `FWS_CMD_SECT;
                        end else begin
                            cyc_data = `FWS_CMD_CHIP;
                        end
                    end
                    default: cyc_data = `FWS_CMD_AA;
                endcase
            end
            `FWS_OP_SUSPEND: begin cyc_addr = addr_reg; cyc_data = `FWS_CMD_SUSP; end
            `FWS_OP_RESUME: begin cyc_addr = addr_reg; cyc_data = `FWS_CMD_RESUME; end
            `FWS_OP_RESET: begin cyc_addr = addr_reg; cyc_data = `FWS_CMD_RESET; end
            default: begin cyc_addr = addr_reg; cyc_data = data_reg; end
        endcase
    end

    wire apb_wr = psel && penable && pwrite && pready;
    wire start_req = apb_wr && (paddr == `FWS_OFF_CTRL) && pwdata[`FWS_CTRL_GO] && !busy;
    wire [2:0] req_op = pwdata[`FWS_CTRL_OP_HI:`FWS_CTRL_OP_LO];
    wire is_erase = (op_reg == `FWS_OP_SECT_ERASE) || (op_reg == `FWS_OP_CHIP_ERASE);
    // a status read at any address flips toggle_bit_one
    wire toggling = flash_dq_in[`FWS_TOG1] != first_reg[`FWS_TOG1];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            op_reg <= 3'h0;
            step_reg <= 3'h0;
            nsteps_reg <= 3'h0;
            addr_reg <= {AW{1'b0}};
            data_reg <= 8'h00;
            rdat_reg <= 8'h00;
            first_reg <= 8'h00;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            susp_reg <= 1'b0;
            ryby_reg <= 1'b1;
            pcnt_reg <= 16'h0000;
            go_reg <= 1'b0;
            recheck_reg <= 1'b0;
            is_wr_reg <= 1'b0;
            busy <= 1'b0;
            prdata <= `FWS_RESET_VAL;
            pready <= 1'b0;
            pslverr <= 1'b0;
            flash_addr <= {AW{1'b0}};
            flash_dq_out <= 8'h00;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
        end else begin
            go_reg <= 1'b0;
            ryby_reg <= ready_busy_n;
            flash_ce_n <= ce_w;
            flash_oe_n <= oe_w;
            flash_we_n <= we_w;
            flash_dq_oe <= doe_w;
            // apb: no wait state, answer in the first access cycle
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    `FWS_OFF_CTRL: prdata <= {28'h000_0000, op_reg, busy};
                    `FWS_OFF_ADDR: prdata <= {{(32-AW){1'b0}}, addr_reg};
                    `FWS_OFF_DATA: prdata <= {24'h00_0000, data_reg};
                    `FWS_OFF_STAT: prdata <= {27'h000_0000, susp_reg, ryby_reg,
                                              fail_reg, done_reg, busy};
                    `FWS_OFF_RDAT: prdata <= {24'h00_0000, rdat_reg};
                    `FWS_OFF_PCNT: prdata <= {16'h0000, pcnt_reg};
                    default: begin
                        prdata <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
            if (apb_wr && !busy) begin
                if (paddr == `FWS_OFF_ADDR) addr_reg <= pwdata[AW-1:0];
                if (paddr == `FWS_OFF_DATA) data_reg <= pwdata[7:0];
            end
            case (state_reg)
                S_IDLE: begin
                    if (start_req) begin
                        op_reg <= req_op;
                        step_reg <= 3'd0;
                        busy <= 1'b1;
                        done_reg <= 1'b0;
                        fail_reg <= 1'b0;
                        pcnt_reg <= 16'h0000;
                        recheck_reg <= 1'b0;
                        case (req_op)
                            `FWS_OP_PROGRAM: nsteps_reg <= 3'd4;
                            `FWS_OP_SECT_ERASE, `FWS_OP_CHIP_ERASE: nsteps_reg <= 3'd6;
                            default: nsteps_reg <= 3'd1;
                        endcase
                        if (req_op == `FWS_OP_SUSPEND) susp_reg <= 1'b1;
                        if (req_op == `FWS_OP_RESUME || req_op == `FWS_OP_RESET)
                            susp_reg <= 1'b0;
                        state_reg <= (req_op == `FWS_OP_READ) ? S_FINAL : S_CMD;
                    end
                end
                S_CMD: begin
                    flash_addr <= cyc_addr;
                    flash_dq_out <= cyc_data;
                    is_wr_reg <= 1'b1;
                    go_reg <= 1'b1;
                    state_reg <= S_CMDW;
                end
                S_CMDW: begin
                    if (cyc_done) begin
                        if (step_reg == nsteps_reg - 3'd1) begin
                            // status valid from last write strobe rise
                            if (op_reg == `FWS_OP_PROGRAM || is_erase) begin
                                state_reg <= S_POLL1;
                            end else begin
                                done_reg <= 1'b1;
                                busy <= 1'b0;
                                state_reg <= S_IDLE;
                            end
                        end else begin
                            step_reg <= step_reg + 3'd1;
                            state_reg <= S_CMD;
                        end
                    end
                end
                S_POLL1, S_POLL2, S_FINAL: begin
                    // poll at target address so polling bit is valid
                    flash_addr <= addr_reg;
                    is_wr_reg <= 1'b0;
                    go_reg <= 1'b1;
                    state_reg <= state_reg + 4'd1;
                end
                S_POLL1W: begin
                    if (cyc_done) begin
                        // whole byte kept, toggle_bit_two beside toggle_bit_one
                        first_reg <= flash_dq_in;
                        pcnt_reg <= pcnt_reg + 16'h0001;
                        state_reg <= S_POLL2;
                    end
                end
                S_POLL2W: begin
                    if (cyc_done) begin
                        pcnt_reg <= pcnt_reg + 16'h0001;
                        // two reads compared; stopped toggle means finished
                        // protected targets also stop after a while
                        if (!toggling) begin
                            state_reg <= S_FINAL;
                        end else if (recheck_reg) begin
                            // still toggling on the recheck: abort with reset
                            fail_reg <= 1'b1;
                            op_reg <= `FWS_OP_RESET;
                            step_reg <= 3'd0;
                            nsteps_reg <= 3'd1;
                            state_reg <= S_CMD;
                        end else if (first_reg[`FWS_TFAIL] || flash_dq_in[`FWS_TFAIL]) begin
                            // toggle may stop as the fail bit rises, or pair status with data
                            recheck_reg <= 1'b1;
                            state_reg <= S_POLL1;
                        end else begin
                            state_reg <= S_POLL1;
                        end
                    end
                end
                S_FINALW: begin
                    if (cyc_done) begin
                        // data taken from the read after toggling stopped
                        rdat_reg <= flash_dq_in;
                        if (op_reg == `FWS_OP_PROGRAM &&
                            flash_dq_in[`FWS_DPOLL] != data_reg[`FWS_DPOLL])
                            fail_reg <= 1'b1;
                        done_reg <= 1'b1;
                        busy <= 1'b0;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verif/fws_flash_model.sv
/*
 * behavioural byte-mode nor flash: command decode, program, erase,
 * suspend and write status. assumes strobes come from one host.
 */
`timescale 1ns/1ns
`default_nettype none

module fws_flash_model #(parameter int PROG_RD = 3, ERASE_RD = 6, FAIL_RD = 4,
    parameter logic [1:0] PROT_SECT = 2'h3) (
    // host strobes and bench fail enable
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic fail_en,
    // address and data
    input wire logic [19:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    output logic [7:0] dq_dev,
    // open-drain busy pin, high pulls low
    output logic rb_oe
);
    logic [7:0] mem [16];
    logic [19:0] pa;
    logic [7:0] pd;
    logic [7:0] c;
    logic [1:0] mode = 2'h0;
    logic [2:0] step = 3'h0;
    logic [1:0] sect = 2'h0;
    logic all = 1'b0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    logic tf = 1'b0;
    logic hit = 1'b0;
    int cnt = 0;

    initial foreach (mem[i]) mem[i] = 8'hFF;
    initial dq_dev = 8'h00;
    assign rb_oe = mode == 2'h1 || mode == 2'h2;

    // decode on the closing write edge
    always @(posedge flash_we_n) begin
        c = flash_dq_out;
        if (mode == 2'h0 && step == 3'h3) begin
            pa = flash_addr;
            pd = c;
            mode = 2'h1;
            cnt = 0;
            step = 3'h0;
        end else if (c == 8'hF0 && mode != 2'h2) begin
            mode = 2'h0;
            step = 3'h0;
            tf = 1'b0;
        end else if (mode == 2'h2 && c == 8'hB0) mode = 2'h3;
        else if (mode == 2'h3 && c == 8'h30) mode = 2'h2;
        else if (mode == 2'h0) begin
            if (step == 3'h2 && c == 8'hA0) step = 3'h3;
            else if (step == 3'h2 && c == 8'h80) step = 3'h4;
            else if (step == 3'h6 && (c == 8'h30 || c == 8'h10)) begin
                all = ~c[5];
                sect = flash_addr[3:2];
                mode = 2'h2;
                cnt = 0;
                step = 3'h0;
            end else if (step != 3'h2 && step < 3'h6 && c == (step[0] ? 8'h55 : 8'hAA))
                step = step + 3'h1;
            else step = 3'h0;
        end
    end

    always @(negedge flash_oe_n) begin
        hit = all || flash_addr[3:2] == sect;
        case (mode)
            2'h1: dq_dev = {flash_addr == pa ? ~pd[7] : pd[7], t1, tf, 5'h00};
            2'h2: dq_dev = {1'b0, t1, 3'h1, t2 & hit, 2'h0};
            2'h3: dq_dev = hit ? {1'b1, t1, 3'h0, t2, 2'h0} : mem[flash_addr[3:0]];
            default: dq_dev = mem[flash_addr[3:0]];
        endcase
    end

    // status moves on at the end of each read cycle
    always @(posedge flash_oe_n) begin
        if (mode == 2'h1 || mode == 2'h2) begin
            t1 = ~t1;
            cnt++;
        end
        if (mode[1] && hit) t2 = ~t2;
        if (mode == 2'h1 && fail_en && cnt >= FAIL_RD) tf = 1'b1;
        if (mode == 2'h1 && !fail_en && cnt >= PROG_RD) begin
            // locked sector: status for a while, then array read, no write
            if (pa[3:2] != PROT_SECT) mem[pa[3:0]] &= pd;
            mode = 2'h0;
        end
        if (mode == 2'h2 && cnt >= ERASE_RD) begin
            // locked sectors skipped; all locked means status only
            foreach (mem[i]) if ((all || i / 4 == sect) && i / 4 != PROT_SECT) mem[i] = 8'hFF;
            mode = 2'h0;
        end
        // released bus must not look like a stale byte
        dq_dev = ~dq_dev;
    end
endmodule
`default_nettype wire

// >>> verif/fws_ctrl_properties.sv
/*
 * port assertions for fws_ctrl: apb handshake and flash strobe shape.
 * assumes 2-clock strobes; bound in at the foot of this file.
 */
`timescale 1ns/1ns
`default_nettype none

module fws_ctrl_properties #(parameter integer AW = 20) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // flash
    input wire logic [AW-1:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pulse(x);
        !x ##1 !x ##1 x;
    endsequence
    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    property p_err;
        pslverr |-> pready && psel && penable;
    endproperty
    property p_we;
        $fell(flash_we_n) |-> s_pulse(flash_we_n);
    endproperty
    property p_oe;
        $fell(flash_oe_n) |-> s_pulse(flash_oe_n);
    endproperty
    property p_ce;
        !flash_we_n || !flash_oe_n |-> !flash_ce_n;
    endproperty
    property p_fight;
        !flash_oe_n |-> !flash_dq_oe && flash_we_n;
    endproperty
    property p_whold;
        !flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out);
    endproperty
    property p_raddr;
        !flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr);
    endproperty
    property p_idle;
        !busy && !$past(busy) |-> flash_ce_n;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
    a_err: assert property (p_err) else $error("pslverr outside access");
    a_we: assert property (p_we) else $error("write strobe width");
    a_oe: assert property (p_oe) else $error("read strobe width");
    a_ce: assert property (p_ce) else $error("strobe without chip select");
    a_fight: assert property (p_fight) else $error("data bus contention");
    a_whold: assert property (p_whold) else $error("write cycle not held");
    a_raddr: assert property (p_raddr) else $error("read address moved");
    a_idle: assert property (p_idle) else $error("bus active while idle");
endmodule

bind fws_ctrl fws_ctrl_properties #(.AW(AW)) u_props (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .busy
);
`default_nettype wire

// >>> verif/fws_ctrl_tb.sv
/*
 * self-checking bench for fws_ctrl against a behavioural flash.
 * assumes fws_flash_model and the bound property checker.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fws_defs.vh"

module fws_ctrl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic fail_en = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_000E;
    logic [31:0] rd;
    logic [31:0] st;
    logic [7:0] mem [16];
    logic [7:0] a;
    logic [7:0] d;
    logic se;
    logic f;
    int err_total = 0;
    int n_compared = 0;
    wire [31:0] prdata;
    wire pready, pslverr, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, rb_oe, busy;
    wire [19:0] flash_addr;
    wire [7:0] flash_dq_out;
    wire [7:0] dq_dev;
    // pull-up on the open-drain pin
    wire ready_busy_n = rb_oe ? 1'b0 : 1'b1;
    wire [7:0] flash_dq_in = flash_dq_oe ? flash_dq_out : dq_dev;

    fws_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .flash_addr, .flash_dq_out, .flash_dq_in, .flash_dq_oe,
        .flash_ce_n, .flash_oe_n, .flash_we_n, .ready_busy_n, .busy);
    fws_flash_model i_flash (.flash_oe_n, .flash_we_n, .fail_en, .flash_addr,
        .flash_dq_out, .dq_dev, .rb_oe);

    always #50 pclk = ~pclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // pready, prdata and pslverr are taken at the rising edge that ends the access
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] dt);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) err_total++;
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input logic v, input int lim);
        int n;
        n = 0;
        @(negedge pclk);
        while (busy !== v && n < lim) begin
            @(negedge pclk);
            n++;
        end
        chk("busy", {31'h0, busy}, {31'h0, v});
    endtask

    task automatic run(input logic [2:0] op, input logic [7:0] ad, input logic [7:0] dt);
        apb(1'b1, `FWS_OFF_ADDR, {24'h00_0000, ad});
        apb(1'b1, `FWS_OFF_DATA, {24'h00_0000, dt});
        apb(1'b1, `FWS_OFF_CTRL, {28'h000_0000, op, 1'b1});
        wt(1'b1, 20);
        wt(1'b0, 4000);
        apb(1'b0, `FWS_OFF_STAT, 32'h0000_0000);
        st = rd & 32'h0000_001F;
        apb(1'b0, `FWS_OFF_RDAT, 32'h0000_0000);
    endtask

    task automatic results;
        if (err_total == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        results();
    end

    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `FWS_OFF_STAT, 32'h0000_0000);
        chk("stat_reset", rd, 32'h0000_0008);
        apb(1'b0, `FWS_OFF_PCNT, 32'h0000_0000);
        chk("pcnt_reset", rd, 32'h0000_0000);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk("unmapped_err", {31'h0, se}, 32'h0000_0001);
        run(`FWS_OP_CHIP_ERASE, 8'h00, 8'h00);
        chk("chip_erase", st, 32'h0000_000A);
        apb(1'b0, `FWS_OFF_PCNT, 32'h0000_0000);
        chk("pcnt_erase", rd, 32'h0000_0008);
        // first two hit one byte: zero, then a one over that zero; third hits the locked sector
        for (int i = 0; i < 20; i++) begin
            a = rnd() & 32'h0000_000F;
            d = rnd() & 32'h0000_00FF;
            if (i < 3) begin
                a = (i < 2) ? 8'h00 : 8'h0C;
                d = {i[0], 7'h00};
            end
            run(`FWS_OP_PROGRAM, a, d);
            // sector 3 is locked in the flash model, so its bytes never change
            if (a[3:2] != 2'h3) mem[a[3:0]] &= d;
            f = mem[a[3:0]][7] != d[7];
            chk("prog_stat", st, {27'h0, 2'b01, f, 2'b10});
            chk("prog_data", rd, {24'h00_0000, mem[a[3:0]]});
        end
        run(`FWS_OP_SECT_ERASE, 8'h05, 8'h00);
        for (int i = 4; i < 8; i++) mem[i] = 8'hFF;
        chk("sect_stat", st, 32'h0000_000A);
        chk("sect_data", rd, 32'h0000_00FF);
        for (int i = 0; i < 16; i++) begin
            run(`FWS_OP_READ, i[7:0], 8'h00);
            chk("array_read", rd, {24'h00_0000, mem[i]});
        end
        fail_en <= 1'b1;
        run(`FWS_OP_PROGRAM, 8'h03, 8'h00);
        chk("fail_stat", st, 32'h0000_000E);
        fail_en <= 1'b0;
        run(`FWS_OP_READ, 8'h03, 8'h00);
        chk("fail_kept", rd, {24'h00_0000, mem[3]});
        for (int k = 4; k < 8; k++) begin
            run(k == 4 ? `FWS_OP_WRITE : k[2:0], 8'h00, 8'hF0);
            chk("misc_stat", st, {27'h0, k == 5, 4'hA});
        end
        results();
    end
endmodule
`default_nettype wire
